// [rtl/lwc_config_regs.sv]
// lens warp configuration bank with indirect table and frame control
`include "lwc_regs.svh"
module lwc_config_regs
  import lwc_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // register port
  input  wire logic [`LWC_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]            regWriteData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [31:0]            regReadData,
  // engine side
  input  wire logic                   tileDone,
  input  wire logic                   frameDone,
  input  wire logic [7:0]             engineTableIndex,
  output logic      [13:0]            engineTableData,
  output lwc_settings_t               settings,
  output lwc_centre_t                 centre,
  output lwc_scale_t                  scale,
  output lwc_tile_t                   tileGeom,
  output lwc_affine_t                 affine,
  output lwc_video_t                  videoMode,
  output logic                        distortionMappingEnable,
  output logic                        lumaBilinear,
  output logic                        busy,
  output logic                        frameStart,
  output logic      [31:0]            outputAddress,
  output logic      [31:0]            chromaOutputAddress
);

  function automatic logic hit(input logic [`LWC_ADDR_W-1:0] a, input logic [`LWC_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  lwc_settings_t settings_reg;
  lwc_centre_t   centre_reg;
  lwc_scale_t    scale_reg;
  lwc_tile_t     tile_reg;
  lwc_affine_t   affine_reg;
  lwc_video_t    mode_reg;
  logic          mapEn_reg;
  logic [7:0]    ptr_reg;
  logic [7:0]    ptr_next;
  logic [13:0]   table_reg [256];
  logic [31:0]   output_base_address_reg;
  logic [31:0]   cbase_reg;
  logic [31:0]   tileStep_reg;
  logic [31:0]   outAddr_reg;
  logic [31:0]   chromaAddr_reg;
  logic [31:0]   readData_reg;
  logic [31:0]   readData_next;
  logic          frameStart_reg;
  lwc_state_t    state_reg;

  wire wrSettings = regWrite && hit(regAddr, `LWC_OFS_SETTINGS);
  wire wrTable    = regWrite && hit(regAddr, `LWC_OFS_TWRITE);
  wire rdTable    = regRead && hit(regAddr, `LWC_OFS_TREAD);
  wire wrPtr      = regWrite && hit(regAddr, `LWC_OFS_PTR);
  wire wrControl  = regWrite && hit(regAddr, `LWC_OFS_CONTROL);
  wire launch     = wrControl && regWriteData[`LWC_CTRL_EN] && (state_reg == LWC_IDLE);

  // settings word; reserved bits are dropped, so stray ones never reach the engine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settings_reg <= '0;
    end else if (wrSettings) begin
      settings_reg.backmapThreshold    <= regWriteData[29:16];
      settings_reg.fixedOutputAddress  <= regWriteData[7];
      settings_reg.lumaInterpSelect    <= regWriteData[6];
      settings_reg.startingBayerColour <= lwc_bayer_t'(regWriteData[5:4]);
      settings_reg.backmapShift        <= regWriteData[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      centre_reg <= '0;
      scale_reg  <= '0;
      tile_reg   <= '0;
    end else if (regWrite) begin
      if (hit(regAddr, `LWC_OFS_CENTRE)) begin
        centre_reg <= {regWriteData[29:16], regWriteData[13:0]};
      end
      if (hit(regAddr, `LWC_OFS_SCALE)) begin
        scale_reg <= regWriteData;
      end
      if (hit(regAddr, `LWC_OFS_TILE)) begin
        tile_reg <= regWriteData[19:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      affine_reg.coefA   <= `LWC_UNITY;
      affine_reg.coefB   <= `LWC_ZERO14;
      affine_reg.coefD   <= `LWC_ZERO14;
      affine_reg.coefE   <= `LWC_UNITY;
      affine_reg.offsetC <= `LWC_ZERO16;
      affine_reg.offsetF <= `LWC_ZERO16;
    end else if (regWrite) begin
      if (hit(regAddr, `LWC_OFS_COEF1)) begin
        affine_reg.coefB <= regWriteData[29:16];
        affine_reg.coefA <= regWriteData[13:0];
      end
      if (hit(regAddr, `LWC_OFS_COEF2)) begin
        affine_reg.coefD   <= regWriteData[29:16];
        affine_reg.offsetC <= regWriteData[15:0];
      end
      if (hit(regAddr, `LWC_OFS_COEF3)) begin
        affine_reg.offsetF <= regWriteData[31:16];
        affine_reg.coefE   <= regWriteData[13:0];
      end
    end
  end

  // peripheral control: mode, mapping enable; enable bit is a self-clearing launch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_reg  <= LWC_MODE_422;
      mapEn_reg <= 1'b0;
    end else if (wrControl) begin
      mode_reg  <= lwc_video_t'(regWriteData[`LWC_CTRL_MODE_HI:`LWC_CTRL_MODE_LO]);
      mapEn_reg <= regWriteData[`LWC_CTRL_MAPEN];
    end
  end

  // output base addresses, aligned down to 32 bytes, and per-tile step
  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_base_address_reg    <= '0;
      cbase_reg    <= '0;
      tileStep_reg <= '0;
    end else if (regWrite) begin
      if (hit(regAddr, `LWC_OFS_OUTPUT_BASE_ADDRESS)) begin
        output_base_address_reg <= {regWriteData[31:`LWC_ALIGN_LO], {`LWC_ALIGN_LO{1'b0}}};
      end
      if (hit(regAddr, `LWC_OFS_CBASE)) begin
        cbase_reg <= {regWriteData[31:`LWC_ALIGN_LO], {`LWC_ALIGN_LO{1'b0}}};
      end
      if (hit(regAddr, `LWC_OFS_TILESTEP)) begin
        tileStep_reg <= {regWriteData[31:`LWC_ALIGN_LO], {`LWC_ALIGN_LO{1'b0}}};
      end
    end
  end

  // frame state: busy from launch until the engine reports the frame done
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg      <= LWC_IDLE;
      frameStart_reg <= 1'b0;
    end else begin
      frameStart_reg <= launch;
      case (state_reg)
        LWC_IDLE: begin
          if (launch) begin
            state_reg <= LWC_RUN;
          end
        end
        LWC_RUN: begin
          if (frameDone) begin
            state_reg <= LWC_IDLE;
          end
        end
        default: state_reg <= LWC_IDLE;
      endcase
    end
  end

  // write address generator
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outAddr_reg    <= '0;
      chromaAddr_reg <= '0;
    end else if (launch) begin
      outAddr_reg    <= output_base_address_reg;
      chromaAddr_reg <= cbase_reg;
    end else if (tileDone && state_reg == LWC_RUN) begin
      if (settings_reg.fixedOutputAddress) begin
        outAddr_reg    <= output_base_address_reg;
        chromaAddr_reg <= cbase_reg;
      end else begin
        outAddr_reg    <= outAddr_reg + tileStep_reg;
        chromaAddr_reg <= chromaAddr_reg + tileStep_reg;
      end
    end
  end

  // table pointer: explicit write wins over increment, 8-bit add wraps
  always_comb begin
    ptr_next = ptr_reg;
    if (wrPtr) begin
      ptr_next = regWriteData[7:0];
    end else if (wrTable || rdTable) begin
      ptr_next = ptr_reg + `LWC_PTR_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrTable) begin
      table_reg[ptr_reg] <= regWriteData[13:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engineTableData <= '0;
    end else begin
      engineTableData <= table_reg[engineTableIndex];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    readData_next = '0;
    case (regAddr)
      `LWC_OFS_CONTROL:  readData_next = {27'h0000000, mode_reg,
                                          state_reg == LWC_RUN, mapEn_reg, 1'b0};
      `LWC_OFS_SETTINGS: readData_next = {2'h0, settings_reg.backmapThreshold, 8'h00,
                                          settings_reg.fixedOutputAddress,
                                          settings_reg.lumaInterpSelect,
                                          settings_reg.startingBayerColour,
                                          settings_reg.backmapShift};
      `LWC_OFS_CENTRE:   readData_next = {2'h0, centre_reg.centreVertical,
                                          2'h0, centre_reg.centreHorizontal};
      `LWC_OFS_SCALE:    readData_next = scale_reg;
      `LWC_OFS_TILE:     readData_next = {12'h000, tile_reg};
      `LWC_OFS_PTR:      readData_next = {24'h000000, ptr_reg};
      `LWC_OFS_TREAD:    readData_next = {18'h00000, table_reg[ptr_reg]};
      `LWC_OFS_COEF1:    readData_next = {2'h0, affine_reg.coefB, 2'h0, affine_reg.coefA};
      `LWC_OFS_COEF2:    readData_next = {2'h0, affine_reg.coefD, affine_reg.offsetC};
      `LWC_OFS_COEF3:    readData_next = {affine_reg.offsetF, 2'h0, affine_reg.coefE};
      `LWC_OFS_OUTPUT_BASE_ADDRESS:    readData_next = output_base_address_reg;
      `LWC_OFS_CBASE:    readData_next = cbase_reg;
      `LWC_OFS_TILESTEP: readData_next = tileStep_reg;
      default:           readData_next = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      readData_reg <= '0;
    end else if (regRead) begin
      readData_reg <= readData_next;
    end else begin
      readData_reg <= '0;
    end
  end

  assign regReadData             = readData_reg;
  assign settings                = settings_reg;
  assign centre                  = centre_reg;
  assign scale                   = scale_reg;
  assign tileGeom                = tile_reg;
  assign affine                  = affine_reg;
  assign videoMode               = mode_reg;
  assign distortionMappingEnable = mapEn_reg;
  // bicubic/bilinear choice only matters outside Bayer mode
  assign lumaBilinear            = settings_reg.lumaInterpSelect
                                   && (mode_reg != LWC_MODE_BAYER);
  assign busy                    = (state_reg == LWC_RUN);
  assign frameStart              = frameStart_reg;
  assign outputAddress           = outAddr_reg;
  assign chromaOutputAddress     = chromaAddr_reg;

  a_ptr_wrap_inc: assert property (@(posedge core_clk) disable iff (reset)
    (rdTable && !wrPtr && ptr_reg == 8'hFF) |=> ptr_reg == 8'h00)
    else $error("table pointer did not wrap");

  a_ptr_write_inc: assert property (@(posedge core_clk) disable iff (reset)
    (wrTable && !wrPtr) |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("table pointer did not advance after write");

  a_table_readback: assert property (@(posedge core_clk) disable iff (reset)
    (rdTable) |=> regReadData == {18'h00000, $past(table_reg[ptr_reg])})
    else $error("table read returned wrong entry");

  a_busy_launch: assert property (@(posedge core_clk) disable iff (reset)
    (launch) |=> busy && frameStart)
    else $error("busy not raised after launch");

  a_busy_clear: assert property (@(posedge core_clk) disable iff (reset)
    (busy && frameDone) |=> !busy)
    else $error("busy not cleared at frame end");

  a_fixed_addr: assert property (@(posedge core_clk) disable iff (reset)
    (busy && tileDone && !launch && settings_reg.fixedOutputAddress)
      |=> outputAddress == $past(output_base_address_reg))
    else $error("fixed address mode moved the output address");

  a_addr_advance: assert property (@(posedge core_clk) disable iff (reset)
    (busy && tileDone && !launch && !settings_reg.fixedOutputAddress)
      |=> outputAddress == $past(outAddr_reg) + $past(tileStep_reg))
    else $error("output address did not advance");

  a_threshold_store: assert property (@(posedge core_clk) disable iff (reset)
    (wrSettings) |=> settings.backmapThreshold == $past(regWriteData[29:16])
      && settings.backmapShift == $past(regWriteData[3:0]))
    else $error("settings word not stored");

  a_field_store: assert property (@(posedge core_clk) disable iff (reset)
    (wrSettings) |=> settings.startingBayerColour == lwc_bayer_t'($past(regWriteData[5:4]))
      && settings.fixedOutputAddress == $past(regWriteData[7])
      && settings.lumaInterpSelect == $past(regWriteData[6]))
    else $error("settings flags not stored");

  a_luma_bayer: assert property (@(posedge core_clk) disable iff (reset)
    (videoMode == LWC_MODE_BAYER) |-> !lumaBilinear)
    else $error("luma interpolation choice applied in Bayer mode");

  a_centre_store: assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && hit(regAddr, `LWC_OFS_CENTRE))
      |=> centre.centreVertical == $past(regWriteData[29:16])
      && centre.centreHorizontal == $past(regWriteData[13:0]))
    else $error("centre word not stored");

  a_scale_store: assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && hit(regAddr, `LWC_OFS_SCALE)) |=> scale == $past(regWriteData))
    else $error("scale word not stored");

  a_tile_store: assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && hit(regAddr, `LWC_OFS_TILE)) |=> tileGeom == $past(regWriteData[19:0]))
    else $error("tile word not stored");

  a_ptr_load: assert property (@(posedge core_clk) disable iff (reset)
    (wrPtr) |=> ptr_reg == $past(regWriteData[7:0]))
    else $error("table pointer not loaded");

  a_ptr_read_inc: assert property (@(posedge core_clk) disable iff (reset)
    (rdTable && !wrPtr) |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("table pointer did not advance after read");

  a_table_store: assert property (@(posedge core_clk) disable iff (reset)
    (wrTable) |=> table_reg[$past(ptr_reg)] == $past(regWriteData[13:0]))
    else $error("table entry not stored");

  a_coef_store: assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && hit(regAddr, `LWC_OFS_COEF1))
      |=> affine.coefB == $past(regWriteData[29:16])
      && affine.coefA == $past(regWriteData[13:0]))
    else $error("coefficients A and B not stored");

  a_offset_store: assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && hit(regAddr, `LWC_OFS_COEF3))
      |=> affine.offsetF == $past(regWriteData[31:16]))
    else $error("offset F not stored");

  a_mode_store: assert property (@(posedge core_clk) disable iff (reset)
    (wrControl)
      |=> videoMode == lwc_video_t'($past(regWriteData[`LWC_CTRL_MODE_HI:`LWC_CTRL_MODE_LO])))
    else $error("video mode not stored");

endmodule

// [rtl/lwc_regs.svh]
// register offsets, field positions and reset values of the warp configuration bank
`ifndef LWC_REGS_SVH
`define LWC_REGS_SVH
`define LWC_ADDR_W        8
`define LWC_OFS_CONTROL   8'h04
`define LWC_OFS_SETTINGS  8'h28
`define LWC_OFS_CENTRE    8'h2C
`define LWC_OFS_SCALE     8'h30
`define LWC_OFS_TILE      8'h34
`define LWC_OFS_PTR       8'h38
`define LWC_OFS_TWRITE    8'h3C
`define LWC_OFS_TREAD     8'h40
`define LWC_OFS_COEF1     8'h44
`define LWC_OFS_COEF2     8'h48
`define LWC_OFS_COEF3     8'h4C
`define LWC_OFS_OUTPUT_BASE_ADDRESS     8'h18
`define LWC_OFS_CBASE     8'h24
`define LWC_OFS_TILESTEP  8'h50
`define LWC_UNITY         14'h1000
`define LWC_ZERO14        14'h0000
`define LWC_ZERO16        16'h0000
`define LWC_CTRL_EN       0
`define LWC_CTRL_MAPEN    1
`define LWC_CTRL_BUSY     2
`define LWC_CTRL_MODE_LO  3
`define LWC_CTRL_MODE_HI  4
`define LWC_ALIGN_LO      5
`define LWC_PTR_ONE       8'h01
`define LWC_TILES_W       16
`endif

// [rtl/lwc_pkg.sv]
// types of the warp configuration bank
package lwc_pkg;
  typedef enum logic [1:0] {
    LWC_BAYER_RED, LWC_BAYER_GRN_RROW, LWC_BAYER_GRN_BROW, LWC_BAYER_BLUE
  } lwc_bayer_t;
  typedef enum logic [1:0] {
    LWC_MODE_422, LWC_MODE_BAYER, LWC_MODE_420, LWC_MODE_UNDEF
  } lwc_video_t;
  typedef struct packed {
    logic [13:0] backmapThreshold;
    logic        fixedOutputAddress;
    logic        lumaInterpSelect;
    lwc_bayer_t  startingBayerColour;
    logic [3:0]  backmapShift;
  } lwc_settings_t;
  typedef struct packed {
    logic [13:0] centreVertical;
    logic [13:0] centreHorizontal;
  } lwc_centre_t;
  typedef struct packed {
    logic [7:0] scaleVerticalLower;
    logic [7:0] scaleVerticalUpper;
    logic [7:0] scaleHorizontalRight;
    logic [7:0] scaleHorizontalLeft;
  } lwc_scale_t;
  typedef struct packed {
    logic [3:0] pixelPadding;
    logic [7:0] outputTileHeight;
    logic [7:0] outputTileWidth;
  } lwc_tile_t;
  typedef struct packed {
    logic [13:0] coefA;
    logic [13:0] coefB;
    logic [15:0] offsetC;
    logic [13:0] coefD;
    logic [13:0] coefE;
    logic [15:0] offsetF;
  } lwc_affine_t;
  typedef enum logic [1:0] {LWC_IDLE, LWC_RUN} lwc_state_t;
endpackage

// [testbench/lwc_config_regs_tb_top.sv]
// self-checking testbench of the lens warp configuration bank
`include "lwc_regs.svh"
module lwc_config_regs_tb_top
  import lwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk;
  logic                   reset;
  logic [`LWC_ADDR_W-1:0] regAddr;
  logic [31:0]            regWriteData;
  logic                   regWrite;
  logic                   regRead;
  logic [31:0]            regReadData;
  logic                   tileDone;
  logic                   frameDone;
  logic [7:0]             engineTableIndex;
  logic [13:0]            engineTableData;
  lwc_settings_t          settings;
  lwc_centre_t            centre;
  lwc_scale_t             scale;
  lwc_tile_t              tileGeom;
  lwc_affine_t            affine;
  lwc_video_t             videoMode;
  logic                   distortionMappingEnable;
  logic                   lumaBilinear;
  logic                   busy;
  logic                   frameStart;
  logic [31:0]            outputAddress;
  logic [31:0]            chromaOutputAddress;
  int                     miscompares;
  int                     compares;
  logic [31:0]            rd;

  lwc_config_regs dut (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .tileDone(tileDone), .frameDone(frameDone), .engineTableIndex(engineTableIndex),
    .engineTableData(engineTableData), .settings(settings), .centre(centre), .scale(scale),
    .tileGeom(tileGeom), .affine(affine), .videoMode(videoMode),
    .distortionMappingEnable(distortionMappingEnable), .lumaBilinear(lumaBilinear),
    .busy(busy), .frameStart(frameStart), .outputAddress(outputAddress),
    .chromaOutputAddress(chromaOutputAddress)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr      <= a;
    regWriteData <= d;
    regWrite     <= 1'b1;
    @(posedge core_clk);
    regWrite     <= 1'b0;
    #1;
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regReadData;
  endtask

  task automatic pulse(input bit isTile);
    @(posedge core_clk);
    if (isTile) tileDone <= 1'b1;
    else frameDone <= 1'b1;
    @(posedge core_clk);
    tileDone  <= 1'b0;
    frameDone <= 1'b0;
    #1;
  endtask

  task automatic test_reset_values();
    rdReg(`LWC_OFS_COEF1, rd); chk(rd, 32'h00001000);
    rdReg(`LWC_OFS_COEF2, rd); chk(rd, 32'h00000000);
    rdReg(`LWC_OFS_COEF3, rd); chk(rd, 32'h00001000);
    rdReg(`LWC_OFS_CENTRE, rd); chk(rd, 32'h00000000);
    rdReg(8'h7C, rd); chk(rd, 32'h00000000);
  endtask

  task automatic test_settings();
    wr(`LWC_OFS_SETTINGS, 32'hFFFFFFFF);
    rdReg(`LWC_OFS_SETTINGS, rd); chk(rd, 32'h3FFF00FF);
    wr(`LWC_OFS_SETTINGS, 32'h2ABC00A5);
    chk({10'h000, settings}, 32'h002ABCA5);
    for (int c = 0; c < 4; c++) begin
      wr(`LWC_OFS_SETTINGS, 32'(c) << 4);
      chk({30'h0, settings.startingBayerColour}, 32'(c));
    end
  endtask

  task automatic test_geometry();
    wr(`LWC_OFS_CENTRE, 32'hFFFFFFFF);
    rdReg(`LWC_OFS_CENTRE, rd); chk(rd, 32'h3FFF3FFF);
    wr(`LWC_OFS_CENTRE, 32'h12340567);
    chk({18'h0, centre.centreVertical}, 32'h1234);
    chk({18'h0, centre.centreHorizontal}, 32'h0567);
    wr(`LWC_OFS_SCALE, 32'h11223344);
    chk({24'h0, scale.scaleVerticalLower}, 32'h11);
    chk({24'h0, scale.scaleHorizontalLeft}, 32'h44);
    rdReg(`LWC_OFS_SCALE, rd); chk(rd, 32'h11223344);
    wr(`LWC_OFS_TILE, 32'hFFFFFFFF);
    rdReg(`LWC_OFS_TILE, rd); chk(rd, 32'h000FFFFF);
    wr(`LWC_OFS_TILE, 32'h00051020);
    chk({12'h0, tileGeom}, 32'h00051020);
  endtask

  task automatic test_affine();
    wr(`LWC_OFS_COEF1, 32'hC001C002);
    rdReg(`LWC_OFS_COEF1, rd); chk(rd, 32'h00010002);
    chk({18'h0, affine.coefA}, 32'h2);
    chk({18'h0, affine.coefB}, 32'h1);
    wr(`LWC_OFS_COEF2, 32'hFFFFFFFF);
    rdReg(`LWC_OFS_COEF2, rd); chk(rd, 32'h3FFFFFFF);
    wr(`LWC_OFS_COEF3, 32'h80014003);
    rdReg(`LWC_OFS_COEF3, rd); chk(rd, 32'h80010003);
    chk({16'h0, affine.offsetF}, 32'h8001);
  endtask

  task automatic test_table();
    wr(`LWC_OFS_PTR, 32'h000001FE);
    rdReg(`LWC_OFS_PTR, rd); chk(rd, 32'h000000FE);
    wr(`LWC_OFS_TWRITE, 32'hFFFF1234);
    wr(`LWC_OFS_TWRITE, 32'h00000ABC);
    rdReg(`LWC_OFS_PTR, rd); chk(rd, 32'h00000000);
    wr(`LWC_OFS_PTR, 32'h000000FE);
    rdReg(`LWC_OFS_TREAD, rd); chk(rd, 32'h00001234);
    rdReg(`LWC_OFS_TREAD, rd); chk(rd, 32'h00000ABC);
    rdReg(`LWC_OFS_PTR, rd); chk(rd, 32'h00000000);
    @(posedge core_clk);
    engineTableIndex <= 8'hFE;
    repeat (2) @(posedge core_clk);
    #1;
    chk({18'h0, engineTableData}, 32'h1234);
  endtask

  task automatic test_modes();
    wr(`LWC_OFS_SETTINGS, 32'h00000040);
    for (int m = 0; m < 4; m++) begin
      wr(`LWC_OFS_CONTROL, (32'(m) << 3) | 32'h2);
      chk({30'h0, videoMode}, 32'(m));
      chk({31'h0, lumaBilinear}, {31'h0, m != 1});
      chk({31'h0, distortionMappingEnable}, 32'h1);
    end
  endtask

  task automatic test_frame();
    wr(`LWC_OFS_OUTPUT_BASE_ADDRESS, 32'h00001000);
    wr(`LWC_OFS_CBASE, 32'h00002000);
    wr(`LWC_OFS_TILESTEP, 32'h00000040);
    for (int f = 0; f < 2; f++) begin
      wr(`LWC_OFS_SETTINGS, f ? 32'h00000080 : 32'h00000000);
      wr(`LWC_OFS_CONTROL, 32'h00000003);
      chk({31'h0, frameStart}, 32'h1);
      chk({31'h0, busy}, 32'h1);
      chk(outputAddress, 32'h00001000);
      chk(chromaOutputAddress, 32'h00002000);
      pulse(1'b1);
      chk({31'h0, frameStart}, 32'h0);
      chk(outputAddress, f ? 32'h00001000 : 32'h00001040);
      chk(chromaOutputAddress, f ? 32'h00002000 : 32'h00002040);
      rdReg(`LWC_OFS_CONTROL, rd); chk(rd, 32'h00000006);
      wr(`LWC_OFS_CONTROL, 32'h00000003);
      chk({31'h0, frameStart}, 32'h0);
      pulse(1'b0);
      chk({31'h0, busy}, 32'h0);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    #(25ns * 20000);
    miscompares++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    regAddr = '0;
    regWriteData = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    tileDone = 1'b0;
    frameDone = 1'b0;
    engineTableIndex = '0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk(affine[87:56], 32'h40000000);
    chk(affine[63:32], 32'h00000000);
    chk(affine[31:0], 32'h10000000);
    chk({31'h0, busy}, 32'h0);
    test_reset_values();
    test_settings();
    test_geometry();
    test_affine();
    test_table();
    test_modes();
    test_frame();
    report_and_stop();
  end
endmodule
